// [ddm_ddr_pins.v]
// ddm_ddr_pins.v: device side of the module's command, clock gate, strobe and mask pins
// assumes all pins are asynchronous to mclk, which runs several times faster than the link clock
`timescale 1ns/1ps
`default_nettype none
`include "ddm_map.vh"

module ddm_ddr_pins #(
  parameter ROW_W = 13,
  parameter COL_W = 10,
  parameter CAS_HALF = 5,
  parameter BURST = 4,
  parameter MEM_ROW_W = 2,
  parameter MEM_COL_W = 6
) (
  // system clock and reset
  input wire mclk,
  input wire rstn,
  // differential link clock and clock gate
  input wire clockTrue,
  input wire clockComplement,
  input wire clockGate,
  // command and address pins
  input wire [1:0] rankSelN,
  input wire rowStrobeN,
  input wire colStrobeN,
  input wire writeEnN,
  input wire bankSelLo,
  input wire bankSelHi,
  input wire [ROW_W-1:0] addrIn,
  // data pins
  input wire [31:0] dqIn,
  output reg [31:0] dqOut_q,
  output reg dqOe_q,
  // strobe pins
  input wire [3:0] dqsIn,
  output reg [3:0] dqsOut_q,
  output reg dqsOe_q,
  // write byte masks
  input wire [3:0] writeByteMask,
  // observed state
  output reg [1:0] powerState_q,
  output reg [7:0] bankOpen_q,
  output reg [ROW_W-1:0] modeBase_q,
  output reg [ROW_W-1:0] modeExt_q
);

  localparam SW = `DDM_SYNC_BASE_W + ROW_W;
  localparam AW = 3 + MEM_ROW_W + MEM_COL_W;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  wire [SW-1:0] pinSync;
  wire ckT, ckC, ckeS, bankHiS, bankLoS, dqsS;
  wire [1:0] selS;
  wire [2:0] cmdS;
  wire [ROW_W-1:0] addrS;
  wire [3:0] maskS;
  wire [31:0] dqS;

  ddm_sync #(.W(SW)) pinSyncInst (
    .mclk(mclk),
    .rstn(rstn),
    .pinIn({clockTrue, clockComplement, clockGate, rankSelN, rowStrobeN, colStrobeN, writeEnN,
            bankSelHi, bankSelLo, addrIn, dqsIn[0], writeByteMask, dqIn}),
    .pinSync_q(pinSync)
  );

  assign {ckT, ckC, ckeS, selS, cmdS, bankHiS, bankLoS, addrS, dqsS, maskS, dqS} = pinSync;

  // ----------------------------------------------------------------
  // link clock crossings
  // ----------------------------------------------------------------
  reg ckPol_q;
  reg dqsPrev_q;
  wire linkOn = (powerState_q != `DDM_PWR_SELF_REF);
  wire ckPos = ckT & ~ckC;
  wire ckNeg = ~ckT & ckC;
  wire rise = linkOn & ckPos & ~ckPol_q;
  wire fall = linkOn & ckNeg & ckPol_q;
  wire crossing = rise | fall;
  wire running = (powerState_q == `DDM_PWR_RUN);
  wire dqsEdge = running & (dqsS != dqsPrev_q);

  // remember the last definite clock polarity and strobe level
  always @(posedge mclk) begin
    if (!rstn) begin
      ckPol_q <= 1'b1; // a link clock already high at release must not count as a rise
      dqsPrev_q <= 1'b0;
    end else begin
      if (ckPos) begin
        ckPol_q <= 1'b1;
      end else if (ckNeg) begin
        ckPol_q <= 1'b0;
      end
      dqsPrev_q <= dqsS;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire cmdValid = (selS == `DDM_RANK_SEL_0) | (selS == `DDM_RANK_SEL_1);
  wire cmdRank = (selS == `DDM_RANK_SEL_1);
  wire [1:0] cmdBank = {bankHiS, bankLoS};
  wire [2:0] cmdRb = {cmdRank, cmdBank};
  wire cmdTake = rise & ckeS & running & cmdValid;
  wire isCmd = cmdTake & (cmdS != `DDM_CMD_NOP);
  wire apBit = addrS[`DDM_PRECHARGE_ALL_BIT];

  // pack rank, bank, low row and column bits plus burst beat into a store address
  function [AW-1:0] memAddr;
    input rank;
    input [1:0] bank;
    input [MEM_ROW_W-1:0] row;
    input [MEM_COL_W-1:0] col;
    input [MEM_COL_W-1:0] beat;
    begin
      memAddr = {rank, bank, row, col + beat};
    end
  endfunction

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rstn) begin
      powerState_q <= `DDM_PWR_RUN;
    end else begin
      case (powerState_q)
        `DDM_PWR_RUN: begin
          if (rise && !ckeS) begin
            if (bankOpen_q != 8'h00) begin
              powerState_q <= `DDM_PWR_PDN_ACT;
            end else if (cmdValid && cmdS == `DDM_CMD_REFRESH) begin
              powerState_q <= `DDM_PWR_SELF_REF;
            end else begin
              powerState_q <= `DDM_PWR_PDN_PRE;
            end
          end
        end
        `DDM_PWR_PDN_PRE, `DDM_PWR_PDN_ACT: begin
          if (rise && ckeS) begin
            powerState_q <= `DDM_PWR_RUN;
          end
        end
        `DDM_PWR_SELF_REF: begin
          if (ckeS) begin
            powerState_q <= `DDM_PWR_RUN;
          end
        end
        default: begin
          powerState_q <= `DDM_PWR_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read burst: preamble, data on every crossing, postamble
  // ----------------------------------------------------------------
  reg rdBusy_q, rdPost_q, rdRank_q, rdAp_q;
  reg [1:0] rdBank_q;
  reg [MEM_ROW_W-1:0] rdRow_q;
  reg [MEM_COL_W-1:0] rdCol_q, rdBeat_q;
  reg [7:0] rdHalf_q;
  reg [ROW_W-1:0] openRow [0:7];
  wire [7:0] rdHalfNext = rdHalf_q + 8'h01;
  wire rdDone = rdBusy_q & crossing & rdPost_q;
  wire [31:0] memRdata;

  always @(posedge mclk) begin
    if (!rstn) begin
      rdBusy_q <= 1'b0;
      rdPost_q <= 1'b0;
      rdRank_q <= 1'b0;
      rdAp_q <= 1'b0;
      rdBank_q <= 2'h0;
      rdRow_q <= {MEM_ROW_W{1'b0}};
      rdCol_q <= {MEM_COL_W{1'b0}};
      rdBeat_q <= {MEM_COL_W{1'b0}};
      rdHalf_q <= 8'h00;
      dqOut_q <= 32'h0000_0000;
      dqOe_q <= 1'b0;
      dqsOut_q <= 4'h0;
      dqsOe_q <= 1'b0;
    end else if (!ckeS) begin
      // outputs drop as soon as the gate falls, no link edge needed
      rdBusy_q <= 1'b0;
      rdPost_q <= 1'b0;
      dqOe_q <= 1'b0;
      dqsOe_q <= 1'b0;
      dqsOut_q <= 4'h0;
    end else if (cmdTake && cmdS == `DDM_CMD_READ) begin
      rdBusy_q <= 1'b1;
      rdPost_q <= 1'b0;
      rdRank_q <= cmdRank;
      rdBank_q <= cmdBank;
      rdRow_q <= openRow[cmdRb][MEM_ROW_W-1:0];
      rdCol_q <= addrS[MEM_COL_W-1:0];
      rdAp_q <= apBit;
      rdBeat_q <= {MEM_COL_W{1'b0}};
      rdHalf_q <= 8'h00;
    end else if (cmdTake && cmdS == `DDM_CMD_TERMINATE && rdBusy_q) begin
      rdBeat_q <= BURST[MEM_COL_W-1:0]; // cut the burst short at the next crossing
    end else if (rdBusy_q && crossing) begin
      rdHalf_q <= rdHalfNext;
      if (rdPost_q) begin
        dqsOe_q <= 1'b0; // end of postamble
        rdBusy_q <= 1'b0;
      end else if (rdBeat_q == BURST[MEM_COL_W-1:0]) begin
        dqOe_q <= 1'b0; // postamble holds strobe low
        dqsOut_q <= 4'h0;
        rdPost_q <= 1'b1;
      end else if (rdHalfNext >= CAS_HALF[7:0]) begin
        dqOut_q <= memRdata;
        dqOe_q <= 1'b1;
        dqsOe_q <= 1'b1;
        dqsOut_q <= ~dqsOut_q;
        rdBeat_q <= rdBeat_q + {{(MEM_COL_W-1){1'b0}}, 1'b1};
      end else if (rdHalfNext == CAS_HALF[7:0] - `DDM_PREAMBLE_HALF) begin
        dqsOe_q <= 1'b1; // preamble: strobe driven low
        dqsOut_q <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // write burst: capture on both strobe edges, masked per byte
  // ----------------------------------------------------------------
  reg wrBusy_q, wrRank_q, wrAp_q;
  reg [1:0] wrBank_q;
  reg [MEM_ROW_W-1:0] wrRow_q;
  reg [MEM_COL_W-1:0] wrCol_q, wrBeat_q;
  wire wrCapture = wrBusy_q & dqsEdge & ckeS;
  wire wrDone = wrCapture & (wrBeat_q == BURST[MEM_COL_W-1:0] - {{(MEM_COL_W-1){1'b0}}, 1'b1});

  always @(posedge mclk) begin
    if (!rstn) begin
      wrBusy_q <= 1'b0;
      wrRank_q <= 1'b0;
      wrAp_q <= 1'b0;
      wrBank_q <= 2'h0;
      wrRow_q <= {MEM_ROW_W{1'b0}};
      wrCol_q <= {MEM_COL_W{1'b0}};
      wrBeat_q <= {MEM_COL_W{1'b0}};
    end else if (cmdTake && cmdS == `DDM_CMD_WRITE) begin
      wrBusy_q <= 1'b1;
      wrRank_q <= cmdRank;
      wrBank_q <= cmdBank;
      wrRow_q <= openRow[cmdRb][MEM_ROW_W-1:0];
      wrCol_q <= addrS[MEM_COL_W-1:0];
      wrAp_q <= apBit;
      wrBeat_q <= {MEM_COL_W{1'b0}};
    end else if (wrCapture) begin
      wrBeat_q <= wrBeat_q + {{(MEM_COL_W-1){1'b0}}, 1'b1};
      if (wrDone) begin
        wrBusy_q <= 1'b0;
      end
    end
  end

  // store port: writes take the address while a beat is captured, reads otherwise
  wire [AW-1:0] memAddrSel = wrCapture ? memAddr(wrRank_q, wrBank_q, wrRow_q, wrCol_q, wrBeat_q)
                                       : memAddr(rdRank_q, rdBank_q, rdRow_q, rdCol_q, rdBeat_q);

  ddm_mem #(.AW(AW), .NB(4)) storeInst (
    .mclk(mclk),
    .addr(memAddrSel),
    .writeEn(wrCapture),
    .byteEn(~maskS),
    .writeData(dqS),
    .readData_q(memRdata)
  );

  // ----------------------------------------------------------------
  // bank rows and mode registers
  // ----------------------------------------------------------------
  integer i;

  always @(posedge mclk) begin
    if (!rstn) begin
      bankOpen_q <= 8'h00;
      modeBase_q <= {ROW_W{1'b0}};
      modeExt_q <= {ROW_W{1'b0}};
      for (i = 0; i < 8; i = i + 1) begin
        openRow[i] <= {ROW_W{1'b0}};
      end
    end else begin
      if (rdDone && rdAp_q) begin
        bankOpen_q[{rdRank_q, rdBank_q}] <= 1'b0;
      end
      if (wrDone && wrAp_q) begin
        bankOpen_q[{wrRank_q, wrBank_q}] <= 1'b0;
      end
      if (isCmd) begin
        case (cmdS)
          `DDM_CMD_ACTIVATE: begin
            bankOpen_q[cmdRb] <= 1'b1;
            openRow[cmdRb] <= addrS;
          end
          `DDM_CMD_PRECHARGE: begin
            if (apBit) begin
              for (i = 0; i < `DDM_BANKS_PER_RANK; i = i + 1) begin
                bankOpen_q[cmdRank * `DDM_BANKS_PER_RANK + i] <= 1'b0;
              end
            end else begin
              bankOpen_q[cmdRb] <= 1'b0;
            end
          end
          `DDM_CMD_MODE_SET: begin
            if (cmdBank == `DDM_MODE_SEL_BASE) begin
              modeBase_q <= addrS;
            end else if (cmdBank == `DDM_MODE_SEL_EXT) begin
              modeExt_q <= addrS;
            end
          end
          default: begin
            modeBase_q <= modeBase_q;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [ddm_map.vh]
// ddm_map.vh: named constants for the module pin interface block
// assumes it is included by the design, checker, controller model and bench files of the ddm block
`ifndef DDM_MAP_VH
`define DDM_MAP_VH

// ----------------------------------------------------------------
// command codes as {row strobe, column strobe, write enable}
// ----------------------------------------------------------------
`define DDM_CMD_MODE_SET  3'h0
`define DDM_CMD_REFRESH   3'h1
`define DDM_CMD_PRECHARGE 3'h2
`define DDM_CMD_ACTIVATE  3'h3
`define DDM_CMD_WRITE     3'h4
`define DDM_CMD_READ      3'h5
`define DDM_CMD_TERMINATE 3'h6
`define DDM_CMD_NOP       3'h7

// ----------------------------------------------------------------
// power states
// ----------------------------------------------------------------
`define DDM_PWR_RUN       2'h0
`define DDM_PWR_PDN_PRE   2'h1
`define DDM_PWR_PDN_ACT   2'h2
`define DDM_PWR_SELF_REF  2'h3

// ----------------------------------------------------------------
// fields, selects and sizes
// ----------------------------------------------------------------
`define DDM_PRECHARGE_ALL_BIT 10
`define DDM_MODE_SEL_BASE 2'h0
`define DDM_MODE_SEL_EXT  2'h1
`define DDM_RANK_SEL_0    2'h2
`define DDM_RANK_SEL_1    2'h1
`define DDM_BANKS_PER_RANK 4
`define DDM_SYNC_BASE_W   47
`define DDM_PREAMBLE_HALF 8'h02

`endif

// [ddm_sync.v]
// ddm_sync.v: two flip-flop synchroniser for a vector of pins
// assumes the pins are sampled by mclk and only the second stage is used
`timescale 1ns/1ps
`default_nettype none

module ddm_sync #(
  parameter W = 8
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // asynchronous pins in, synchronised copy out
  input wire [W-1:0] pinIn,
  output reg [W-1:0] pinSync_q
);

  reg [W-1:0] stage1_q;

  // ----------------------------------------------------------------
  // two stages; the first feeds nothing but the second
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rstn) begin
      stage1_q <= {W{1'b0}};
      pinSync_q <= {W{1'b0}};
    end else begin
      stage1_q <= pinIn;
      pinSync_q <= stage1_q;
    end
  end

endmodule
`default_nettype wire

// [ddm_mem.v]
// ddm_mem.v: small byte-writable store behind the data pins
// assumes one access per cycle; read data is registered
`timescale 1ns/1ps
`default_nettype none

module ddm_mem #(
  parameter AW = 11,
  parameter NB = 4
) (
  // clock
  input wire mclk,
  // access port
  input wire [AW-1:0] addr,
  input wire writeEn,
  input wire [NB-1:0] byteEn,
  input wire [NB*8-1:0] writeData,
  output reg [NB*8-1:0] readData_q
);

  reg [NB*8-1:0] store [0:(1<<AW)-1];
  integer b;

  // ----------------------------------------------------------------
  // byte-lane write, registered read
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (writeEn) begin
      for (b = 0; b < NB; b = b + 1) begin
        if (byteEn[b]) begin
          store[addr][b*8 +: 8] <= writeData[b*8 +: 8];
        end
      end
    end
    readData_q <= store[addr];
  end

endmodule
`default_nettype wire

// [ddm_ddr_pins_chk.sv]
// ddm_ddr_pins_chk.sv: assertions on the pins of the ddm pin block
// assumes pins hold 8 mclk around each link crossing and mclk outruns the link clock
`timescale 1ns/1ps
`default_nettype none
`include "ddm_map.vh"

module ddm_ddr_pins_chk #(
  parameter ROW_W = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // controller pins
  input wire logic clockGate,
  input wire logic [1:0] rankSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnN,
  input wire logic bankSelLo,
  input wire logic bankSelHi,
  input wire logic [ROW_W-1:0] addrIn,
  // block outputs
  input wire logic [31:0] dqOut_q,
  input wire logic dqOe_q,
  input wire logic [3:0] dqsOut_q,
  input wire logic dqsOe_q,
  input wire logic [1:0] powerState_q,
  input wire logic [7:0] bankOpen_q,
  input wire logic [ROW_W-1:0] modeBase_q
);
  // --------------------
  // pin relations
  // --------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // command and bank as seen at the pins
  wire logic [2:0] cmd = {rowStrobeN, colStrobeN, writeEnN};
  wire logic [1:0] bank = {bankSelHi, bankSelLo};

  property p_act;
    (bankOpen_q & ~$past(bankOpen_q)) != 8'h0 |-> $past(cmd, 3) == `DDM_CMD_ACTIVATE && ^$past(rankSelN, 3);
  endproperty
  a_act: assert property (p_act) else $error("bank opened without a selected activate");
  property p_base;
    $changed(modeBase_q) |-> $past(cmd, 3) == `DDM_CMD_MODE_SET && $past(bank, 3) == `DDM_MODE_SEL_BASE
      && modeBase_q == $past(addrIn, 3);
  endproperty
  a_base: assert property (p_base) else $error("mode word loaded wrongly");
  property p_strobe;
    dqOe_q |-> dqsOe_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("read data without strobe");
  property p_align;
    dqOe_q && $changed(dqOut_q) |-> $changed(dqsOut_q[0]);
  endproperty
  a_align: assert property (p_align) else $error("read data moved without strobe edge");
  property p_gate_off;
    (!clockGate) [*4] |=> !dqOe_q && !dqsOe_q;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("outputs driven with gate low");
  property p_sr_exit;
    clockGate [*5] |-> powerState_q != `DDM_PWR_SELF_REF;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh held with gate high");
  property p_pd_act;
    $changed(powerState_q) && powerState_q == `DDM_PWR_PDN_ACT |-> $past(bankOpen_q) != 8'h0;
  endproperty
  a_pd_act: assert property (p_pd_act) else $error("active power-down with no open bank");
  property p_pd_pre;
    $changed(powerState_q) && powerState_q == `DDM_PWR_PDN_PRE |-> $past(bankOpen_q) == 8'h0 && !$past(clockGate, 3);
  endproperty
  a_pd_pre: assert property (p_pd_pre) else $error("precharge power-down entered wrongly");
  property p_hold;
    powerState_q != `DDM_PWR_RUN && $past(powerState_q) != `DDM_PWR_RUN |-> $stable(bankOpen_q) && $stable(modeBase_q);
  endproperty
  a_hold: assert property (p_hold) else $error("state changed while powered down");

  // main scenarios reached
  c_read: cover property (dqOe_q && dqsOut_q[0]);
  c_apd: cover property (powerState_q == `DDM_PWR_PDN_ACT);
  c_sr: cover property (powerState_q == `DDM_PWR_SELF_REF);
endmodule

bind ddm_ddr_pins ddm_ddr_pins_chk #(.ROW_W(ROW_W)) u_chk (.mclk, .rstn, .clockGate, .rankSelN, .rowStrobeN,
  .colStrobeN, .writeEnN, .bankSelLo, .bankSelHi, .addrIn, .dqOut_q, .dqOe_q, .dqsOut_q, .dqsOe_q,
  .powerState_q, .bankOpen_q, .modeBase_q);
`default_nettype wire

// [ddm_ctrl_model.sv]
// ddm_ctrl_model.sv: behavioural memory controller facing the ddm pin block
// assumes the testbench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
`include "ddm_map.vh"

module ddm_ctrl_model (
  // system clock and link clock enable
  input wire logic mclk,
  input wire logic linkRun,
  // link clock and gate
  output logic clockTrue,
  output logic clockComplement,
  output logic clockGate,
  // command and address
  output logic [1:0] rankSelN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeEnN,
  output logic bankSelLo,
  output logic bankSelHi,
  output logic [12:0] addrIn,
  // write data, strobe and mask
  output logic [31:0] dqIn,
  output logic [3:0] dqsIn,
  output logic [3:0] writeByteMask
);
  // --------------------
  // link clock and tasks
  // --------------------
  // link clock of unrelated phase, stands still while linkRun is low
  initial begin
    {clockTrue, clockComplement} = 2'h1;
    {clockGate, rankSelN, rowStrobeN, colStrobeN, writeEnN} = 6'h3f;
    {bankSelHi, bankSelLo, addrIn, dqIn, dqsIn, writeByteMask} = 55'h0;
    forever begin
      #32;
      if (linkRun) begin
        clockTrue = ~clockTrue;
        clockComplement = ~clockComplement;
      end
    end
  end

  // one command, held from the falling crossing before to the one after
  task automatic cmd(input logic [1:0] sel, input logic [2:0] code, input logic [1:0] bank,
                     input logic [12:0] addr, input logic gate);
    @(negedge clockTrue);
    @(posedge mclk);
    rankSelN <= sel;
    {rowStrobeN, colStrobeN, writeEnN} <= code;
    {bankSelHi, bankSelLo} <= bank;
    addrIn <= addr;
    clockGate <= gate;
    @(posedge clockTrue);
    @(negedge clockTrue);
    @(posedge mclk);
    rankSelN <= 2'h3;
    {rowStrobeN, colStrobeN, writeEnN} <= `DDM_CMD_NOP;
    {bankSelHi, bankSelLo} <= ~bank; // released lines show the inverse
    addrIn <= ~addr;
  endtask

  // gate change with no link edge involved
  task automatic setGate(input logic gate);
    @(posedge mclk);
    clockGate <= gate;
  endtask

  // four beats, each strobe edge in the middle of its data bit
  task automatic wr(input logic [127:0] data, input logic [15:0] mask);
    for (int k = 0; k < 4; k++) begin
      repeat (4) @(posedge mclk);
      dqIn <= data[32*k +: 32];
      writeByteMask <= mask[4*k +: 4];
      repeat (4) @(posedge mclk);
      dqsIn <= ~dqsIn;
    end
    repeat (4) @(posedge mclk);
    dqIn <= ~dqIn;
    writeByteMask <= ~writeByteMask;
  endtask
endmodule
`default_nettype wire

// [ddm_ddr_pins_tb.sv]
// ddm_ddr_pins_tb.sv: self-checking bench for the ddm pin block
// assumes ddm_ctrl_model drives every pin and the checker is bound to the block
`timescale 1ns/1ps
`default_nettype none
`include "ddm_map.vh"

module ddm_ddr_pins_tb;
  logic mclk;
  logic rstn;
  logic linkRun;
  int nMismatch = 0;
  int checkCount = 0;
  int cycles = 0;
  wire clockTrue, clockComplement, clockGate, rowStrobeN, colStrobeN, writeEnN, bankSelLo, bankSelHi;
  wire dqOe_q, dqsOe_q;
  wire [1:0] rankSelN, powerState_q;
  wire [12:0] addrIn, modeBase_q, modeExt_q;
  wire [31:0] dqIn, dqOut_q;
  wire [3:0] dqsIn, dqsOut_q, writeByteMask;
  wire [7:0] bankOpen_q;

  // --------------------
  // instances and clock
  // --------------------
  ddm_ddr_pins u_dut (.mclk, .rstn, .clockTrue, .clockComplement, .clockGate, .rankSelN, .rowStrobeN,
    .colStrobeN, .writeEnN, .bankSelLo, .bankSelHi, .addrIn, .dqIn, .dqOut_q, .dqOe_q, .dqsIn, .dqsOut_q,
    .dqsOe_q, .writeByteMask, .powerState_q, .bankOpen_q, .modeBase_q, .modeExt_q);
  ddm_ctrl_model u_ctrl (.mclk, .linkRun, .clockTrue, .clockComplement, .clockGate, .rankSelN, .rowStrobeN,
    .colStrobeN, .writeEnN, .bankSelLo, .bankSelHi, .addrIn, .dqIn, .dqsIn, .writeByteMask);

  // 250 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nMismatch++;
      finishTest;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait for a power state
  task automatic waitState(input logic [1:0] s);
    for (int i = 0; i < 200 && powerState_q !== s; i++)
      @(posedge mclk);
    check(32'(powerState_q), 32'(s));
  endtask

  // read four words from rank 0 bank 2 and compare them
  task automatic readBurst(input logic [12:0] addr, input logic [127:0] exp);
    int i;
    u_ctrl.cmd(2'h2, `DDM_CMD_READ, 2'h2, addr, 1'b1);
    for (int k = 0; k < 4; k++) begin
      for (i = 0; i < 64 && !(dqOe_q === 1'b1 && dqsOut_q === {4{~k[0]}}); i++)
        @(posedge mclk);
      check(dqOut_q, exp[32*k +: 32]);
    end
    for (i = 0; i < 64 && dqsOe_q !== 1'b0; i++)
      @(posedge mclk);
    check(32'(dqOe_q), 32'h0);
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic runMode;
    u_ctrl.cmd(2'h2, `DDM_CMD_MODE_SET, 2'h0, 13'h0123, 1'b1);
    u_ctrl.cmd(2'h1, `DDM_CMD_MODE_SET, 2'h1, 13'h1a5a, 1'b1);
    u_ctrl.cmd(2'h3, `DDM_CMD_MODE_SET, 2'h0, 13'h0fff, 1'b1);
    u_ctrl.cmd(2'h2, `DDM_CMD_MODE_SET, 2'h2, 13'h0fff, 1'b1);
    repeat (8) @(posedge mclk);
    check(32'(modeBase_q), 32'h0123);
    check(32'(modeExt_q), 32'h1a5a);
    $display("test mode done");
  endtask

  task automatic runBank;
    u_ctrl.cmd(2'h2, `DDM_CMD_ACTIVATE, 2'h2, 13'h0002, 1'b1);
    u_ctrl.cmd(2'h2, `DDM_CMD_ACTIVATE, 2'h1, 13'h0001, 1'b1);
    u_ctrl.cmd(2'h1, `DDM_CMD_ACTIVATE, 2'h1, 13'h0003, 1'b1);
    u_ctrl.cmd(2'h3, `DDM_CMD_ACTIVATE, 2'h3, 13'h0000, 1'b1);
    u_ctrl.cmd(2'h0, `DDM_CMD_ACTIVATE, 2'h0, 13'h0000, 1'b1);
    repeat (8) @(posedge mclk);
    check(32'(bankOpen_q), 32'h26);
    u_ctrl.cmd(2'h2, `DDM_CMD_PRECHARGE, 2'h1, 13'h0000, 1'b1);
    repeat (8) @(posedge mclk);
    check(32'(bankOpen_q), 32'h24);
    $display("test bank done");
  endtask

  task automatic runData;
    logic [127:0] w1, w2, exp;
    w1 = 128'h4444d4d4_3333c3c3_2222b2b2_1111a1a1;
    w2 = 128'hdddddddd_cccccccc_bbbbbbbb_aaaaaaaa;
    for (int i = 0; i < 16; i++)
      exp[8*i +: 8] = (16'h05af >> i) & 1 ? w1[8*i +: 8] : w2[8*i +: 8];
    u_ctrl.cmd(2'h2, `DDM_CMD_WRITE, 2'h2, 13'h0004, 1'b1);
    u_ctrl.wr(w1, 16'h0000);
    u_ctrl.cmd(2'h2, `DDM_CMD_WRITE, 2'h2, 13'h0004, 1'b1);
    u_ctrl.wr(w2, 16'h05af);
    readBurst(13'h0004, exp);
    readBurst(13'h0404, exp);
    repeat (8) @(posedge mclk);
    check(32'(bankOpen_q), 32'h20);
    $display("test data done");
  endtask

  task automatic runPower;
    u_ctrl.cmd(2'h3, `DDM_CMD_NOP, 2'h0, 13'h0, 1'b0);
    waitState(`DDM_PWR_PDN_ACT);
    u_ctrl.cmd(2'h2, `DDM_CMD_ACTIVATE, 2'h0, 13'h0, 1'b0);
    u_ctrl.cmd(2'h3, `DDM_CMD_NOP, 2'h0, 13'h0, 1'b1);
    waitState(`DDM_PWR_RUN);
    check(32'(bankOpen_q), 32'h20);
    u_ctrl.cmd(2'h1, `DDM_CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    repeat (8) @(posedge mclk);
    check(32'(bankOpen_q), 32'h00);
    u_ctrl.cmd(2'h3, `DDM_CMD_NOP, 2'h0, 13'h0, 1'b0);
    waitState(`DDM_PWR_PDN_PRE);
    u_ctrl.cmd(2'h3, `DDM_CMD_NOP, 2'h0, 13'h0, 1'b1);
    waitState(`DDM_PWR_RUN);
    u_ctrl.cmd(2'h2, `DDM_CMD_REFRESH, 2'h0, 13'h0, 1'b0);
    waitState(`DDM_PWR_SELF_REF);
    linkRun <= 1'b0;
    repeat (40) @(posedge mclk);
    check(32'(powerState_q), 32'(`DDM_PWR_SELF_REF));
    u_ctrl.setGate(1'b1);
    waitState(`DDM_PWR_RUN);
    linkRun <= 1'b1;
    $display("test power done");
  endtask

  task automatic runAbort;
    u_ctrl.cmd(2'h2, `DDM_CMD_ACTIVATE, 2'h2, 13'h0002, 1'b1);
    u_ctrl.cmd(2'h2, `DDM_CMD_READ, 2'h2, 13'h0004, 1'b1);
    for (int i = 0; i < 64 && dqOe_q !== 1'b1; i++)
      @(posedge mclk);
    u_ctrl.setGate(1'b0);
    repeat (5) @(posedge mclk);
    check(32'({dqOe_q, dqsOe_q}), 32'h0);
    waitState(`DDM_PWR_PDN_ACT);
    u_ctrl.cmd(2'h3, `DDM_CMD_NOP, 2'h0, 13'h0, 1'b1);
    waitState(`DDM_PWR_RUN);
    $display("test abort done");
  endtask

  // a burst stop during the preamble leaves no data on the pins
  task automatic runStop;
    int i;
    logic seen;
    seen = 1'b0;
    u_ctrl.cmd(2'h2, `DDM_CMD_READ, 2'h2, 13'h0004, 1'b1);
    u_ctrl.cmd(2'h2, `DDM_CMD_TERMINATE, 2'h2, 13'h0004, 1'b1);
    check(32'(dqsOe_q), 32'h1);
    for (i = 0; i < 64 && dqsOe_q !== 1'b0; i++) begin
      seen = seen | (dqOe_q === 1'b1);
      @(posedge mclk);
    end
    check(32'({seen, dqsOe_q}), 32'h0);
    $display("test stop done");
  endtask

  // reset, then every scenario in turn
  initial begin
    rstn = 1'b0;
    linkRun = 1'b1;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    runMode;
    runBank;
    runData;
    runPower;
    runAbort;
    runStop;
    finishTest;
  end
endmodule
`default_nettype wire
